// ### eadf_params.svh
// timing counts and opcode encodings for the effective address and flag control decoder
`ifndef EADF_PARAMS_SVH
`define EADF_PARAMS_SVH
`define EADF_OP_CARRY_CLEAR 8'hF8
`define EADF_OP_CARRY_INVERT 8'hF5
`define EADF_OP_CARRY_SET 8'hF9
`define EADF_OP_DIR_CLEAR 8'hFC
`define EADF_OP_DIR_SET 8'hFD
`define EADF_OP_IRQ_CLEAR 8'hFA
`define EADF_OP_IRQ_SET 8'hFB
`define EADF_OP_LOCK 8'hF0
`define EADF_OP_HALT 8'hF4
`define EADF_OP_WAIT 8'h9B
`define EADF_OP_NOP 8'h90
`define EADF_FLAG_CYCLES 4'h2
`define EADF_NOP_CYCLES 4'h3
`define EADF_WAIT_CYCLES 4'h6
`define EADF_EA_CYCLES 4'h4
`define EADF_WORD_XFER_CYCLES 4'h4
`define EADF_MOD_REG 2'h3
`define EADF_MOD_NODISP 2'h0
`define EADF_MOD_DISP8 2'h1
`define EADF_MOD_DISP16 2'h2
`define EADF_RM_DIRECT 3'h6
`define EADF_SEG_PREFIX_MASK 8'hE7
`define EADF_SEG_PREFIX_VAL 8'h26
`define EADF_SEG_FIELD_POS 3
`endif

// ### eadf_pkg.sv
// types shared by the effective address and flag control decoder
package eadf_pkg;
  typedef enum logic [1:0] {
    EADF_SEG_EXTRA,
    EADF_SEG_CODE,
    EADF_SEG_STACK,
    EADF_SEG_DATA
  } eadf_seg_t;

  typedef struct packed {
    logic [15:0] ax;
    logic [15:0] cx;
    logic [15:0] dx;
    logic [15:0] bx;
    logic [15:0] bp;
    logic [15:0] si;
    logic [15:0] di;
  } eadf_regs_t;

  typedef struct packed {
    logic carry;
    logic direction;
    logic irq_enable;
  } eadf_flags_t;

  typedef struct packed {
    logic [15:0] effective_address;
    eadf_seg_t seg;
    logic is_reg;
    logic [2:0] reg_num;
    logic [7:0] byte_reg_val;
    logic [3:0] cycles;
  } eadf_ea_t;
endpackage : eadf_pkg

// ### eadf_decode.sv
// effective address, segment and processor-control decoder
`timescale 1ns/1ps
`default_nettype none
`include "eadf_params.svh"

module eadf_decode (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic byte_valid,
  input wire logic [7:0] byte_in,
  input wire eadf_pkg::eadf_regs_t regs,
  input wire logic string_dest,
  input wire logic word_op,
  input wire logic [1:0] mem_xfers,
  input wire logic test_n,
  input wire logic irq_req,
  output logic byte_ready,
  output eadf_pkg::eadf_flags_t flags,
  output logic lock_active,
  output logic halted,
  output logic [3:0] op_cycles,
  output logic op_done,
  output eadf_pkg::eadf_ea_t ea_out,
  output logic ea_valid,
  output logic [5:0] xfer_cycles
);
  typedef enum logic [2:0] {
    ST_OPCODE, ST_MODRM, ST_DISP_LO, ST_DISP_HI, ST_EXEC, ST_WAIT, ST_HALT
  } eadf_state_t;

  function automatic logic [7:0] byte_reg_sel(input logic [2:0] code,
                                              input eadf_pkg::eadf_regs_t r);
    unique case (code)
      3'h0: byte_reg_sel = r.ax[7:0];
      3'h1: byte_reg_sel = r.cx[7:0];
      3'h2: byte_reg_sel = r.dx[7:0];
      3'h3: byte_reg_sel = r.bx[7:0];
      3'h4: byte_reg_sel = r.ax[15:8];
      3'h5: byte_reg_sel = r.cx[15:8];
      3'h6: byte_reg_sel = r.dx[15:8];
      3'h7: byte_reg_sel = r.bx[15:8];
    endcase
  endfunction

  // test pin comes from outside: three stages, change counts when last two agree
  logic [2:0] test_sync_q;
  logic test_low_q;
  logic test_low_d;
  logic [2:0] irq_sync_q;
  logic irq_seen_q;
  logic irq_seen_d;

  eadf_state_t state_q, state_d;
  eadf_pkg::eadf_flags_t flags_q, flags_d;
  eadf_pkg::eadf_seg_t seg_ovr_q, seg_ovr_d;
  eadf_pkg::eadf_ea_t ea_q, ea_d;
  logic ovr_q, ovr_d;
  logic lock_pend_q, lock_pend_d;
  logic lock_q, lock_d;
  logic [1:0] mod_q, mod_d;
  logic [2:0] rm_q, rm_d;
  logic [7:0] disp_lo_q, disp_lo_d;
  logic [3:0] cnt_q, cnt_d;
  logic [3:0] cyc_q, cyc_d;
  logic done_q, done_d;
  logic eav_q, eav_d;
  logic [5:0] xfer_q, xfer_d;
  logic [15:0] base_sum;
  logic [15:0] disp;
  logic uses_bp;

  always_comb begin
    test_low_d = test_low_q;
    if (test_sync_q[2] == test_sync_q[1]) begin
      test_low_d = ~test_sync_q[2];
    end
    irq_seen_d = irq_seen_q;
    if (irq_sync_q[2] == irq_sync_q[1]) begin
      irq_seen_d = irq_sync_q[2];
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      test_sync_q <= 3'h7;
      test_low_q <= 1'b0;
      irq_sync_q <= 3'h0;
      irq_seen_q <= 1'b0;
    end else begin
      test_sync_q <= {test_sync_q[1:0], test_n};
      test_low_q <= test_low_d;
      irq_sync_q <= {irq_sync_q[1:0], irq_req};
      irq_seen_q <= irq_seen_d;
    end
  end

  // address sum follows the mode byte being taken, so mod 00 forms see their own r/m
  always_comb begin
    unique case (rm_d)
      3'h0: base_sum = 16'(regs.bx + regs.si);
      3'h1: base_sum = 16'(regs.bx + regs.di);
      3'h2: base_sum = 16'(regs.bp + regs.si);
      3'h3: base_sum = 16'(regs.bp + regs.di);
      3'h4: base_sum = regs.si;
      3'h5: base_sum = regs.di;
      3'h6: base_sum = regs.bp;
      3'h7: base_sum = regs.bx;
    endcase
    uses_bp = (rm_d == 3'h2) || (rm_d == 3'h3) || (rm_d == 3'h6);
  end

  always_comb begin
    state_d = state_q;
    flags_d = flags_q;
    seg_ovr_d = seg_ovr_q;
    ovr_d = ovr_q;
    lock_pend_d = lock_pend_q;
    lock_d = lock_q;
    mod_d = mod_q;
    rm_d = rm_q;
    disp_lo_d = disp_lo_q;
    cnt_d = cnt_q;
    cyc_d = cyc_q;
    done_d = 1'b0;
    eav_d = 1'b0;
    ea_d = ea_q;
    xfer_d = xfer_q;
    disp = 16'h0000;
    unique case (state_q)
      ST_OPCODE: begin
        if (byte_valid) begin
          if ((byte_in & `EADF_SEG_PREFIX_MASK) == `EADF_SEG_PREFIX_VAL) begin
            ovr_d = 1'b1;
            seg_ovr_d = eadf_pkg::eadf_seg_t'(byte_in[`EADF_SEG_FIELD_POS +: 2]);
          end else begin
            cyc_d = `EADF_FLAG_CYCLES;
            state_d = ST_EXEC;
            unique case (byte_in)
              `EADF_OP_CARRY_CLEAR: flags_d.carry = 1'b0;
              `EADF_OP_CARRY_INVERT: flags_d.carry = ~flags_q.carry;
              `EADF_OP_CARRY_SET: flags_d.carry = 1'b1;
              `EADF_OP_DIR_CLEAR: flags_d.direction = 1'b0;
              `EADF_OP_DIR_SET: flags_d.direction = 1'b1;
              `EADF_OP_IRQ_CLEAR: flags_d.irq_enable = 1'b0;
              `EADF_OP_IRQ_SET: flags_d.irq_enable = 1'b1;
              `EADF_OP_LOCK: lock_pend_d = 1'b1;
              `EADF_OP_HALT: state_d = ST_HALT;
              `EADF_OP_WAIT: begin
                cyc_d = `EADF_WAIT_CYCLES;
                state_d = ST_WAIT;
              end
              `EADF_OP_NOP: cyc_d = `EADF_NOP_CYCLES;
              default: begin
                // any other opcode is taken as carrying a mode byte
                lock_d = lock_pend_q;
                lock_pend_d = 1'b0;
                state_d = ST_MODRM;
              end
            endcase
            cnt_d = 4'h1;
          end
        end
      end
      ST_MODRM: begin
        if (byte_valid) begin
          mod_d = byte_in[7:6];
          rm_d = byte_in[2:0];
          if (byte_in[7:6] == `EADF_MOD_REG || (byte_in[7:6] == `EADF_MOD_NODISP
              && byte_in[2:0] != `EADF_RM_DIRECT)) begin
            state_d = ST_EXEC;
          end else begin
            state_d = ST_DISP_LO;
          end
          cnt_d = 4'h0;
        end
      end
      ST_DISP_LO: begin
        if (byte_valid) begin
          disp_lo_d = byte_in;
          state_d = (mod_q == `EADF_MOD_DISP8) ? ST_EXEC : ST_DISP_HI;
        end
      end
      ST_DISP_HI: begin
        if (byte_valid) begin
          disp_lo_d = disp_lo_q;
          state_d = ST_EXEC;
        end
      end
      ST_EXEC: begin
        cnt_d = 4'(cnt_q + 4'h1);
        if (cnt_q >= cyc_q) begin
          done_d = 1'b1;
          state_d = ST_OPCODE;
          ovr_d = 1'b0;
          lock_d = 1'b0;
        end
      end
      ST_WAIT: begin
        cnt_d = (cnt_q < cyc_q) ? 4'(cnt_q + 4'h1) : cnt_q;
        if (test_low_q && cnt_q >= cyc_q) begin
          done_d = 1'b1;
          state_d = ST_OPCODE;
        end
      end
      ST_HALT: begin
        if (irq_seen_q) begin
          done_d = 1'b1;
          state_d = ST_OPCODE;
        end
      end
    endcase
    // address formation once mode byte and displacement are in hand
    if ((state_q == ST_MODRM && byte_valid && state_d == ST_EXEC)
        || ((state_q == ST_DISP_LO || state_q == ST_DISP_HI) && byte_valid
            && state_d == ST_EXEC)) begin
      if (state_q == ST_DISP_HI) begin
        disp = {byte_in, disp_lo_q};
      end else if (state_q == ST_DISP_LO) begin
        disp = {{8{byte_in[7]}}, byte_in};
      end
      ea_d.is_reg = (mod_d == `EADF_MOD_REG);
      ea_d.reg_num = rm_d;
      ea_d.byte_reg_val = byte_reg_sel(rm_d, regs);
      if (mod_d == `EADF_MOD_REG) begin
        ea_d.effective_address = 16'h0000;
      end else if (mod_d == `EADF_MOD_NODISP && rm_d == `EADF_RM_DIRECT) begin
        ea_d.effective_address = disp;
      end else begin
        ea_d.effective_address = 16'(base_sum + disp);
      end
      if (string_dest) begin
        ea_d.seg = eadf_pkg::EADF_SEG_EXTRA;
      end else if (ovr_q) begin
        ea_d.seg = seg_ovr_q;
      end else if (mod_d != `EADF_MOD_REG && uses_bp
                   && !(mod_d == `EADF_MOD_NODISP && rm_d == `EADF_RM_DIRECT)) begin
        ea_d.seg = eadf_pkg::EADF_SEG_STACK;
      end else begin
        ea_d.seg = eadf_pkg::EADF_SEG_DATA;
      end
      ea_d.cycles = ea_d.is_reg ? 4'h0 : `EADF_EA_CYCLES;
      cyc_d = ea_d.cycles;
      xfer_d = word_op ? 6'(mem_xfers * `EADF_WORD_XFER_CYCLES) : 6'h00;
      eav_d = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_q <= ST_OPCODE;
      flags_q <= '0;
      seg_ovr_q <= eadf_pkg::EADF_SEG_DATA;
      ovr_q <= 1'b0;
      lock_pend_q <= 1'b0;
      lock_q <= 1'b0;
      mod_q <= 2'h0;
      rm_q <= 3'h0;
      disp_lo_q <= 8'h00;
      cnt_q <= 4'h0;
      cyc_q <= 4'h0;
      done_q <= 1'b0;
      eav_q <= 1'b0;
      ea_q <= '0;
      xfer_q <= 6'h00;
    end else begin
      state_q <= state_d;
      flags_q <= flags_d;
      seg_ovr_q <= seg_ovr_d;
      ovr_q <= ovr_d;
      lock_pend_q <= lock_pend_d;
      lock_q <= lock_d;
      mod_q <= mod_d;
      rm_q <= rm_d;
      disp_lo_q <= disp_lo_d;
      cnt_q <= cnt_d;
      cyc_q <= cyc_d;
      done_q <= done_d;
      eav_q <= eav_d;
      ea_q <= ea_d;
      xfer_q <= xfer_d;
    end
  end

  assign byte_ready = (state_q == ST_OPCODE) || (state_q == ST_MODRM)
                      || (state_q == ST_DISP_LO) || (state_q == ST_DISP_HI);
  assign flags = flags_q;
  assign lock_active = lock_q;
  assign halted = (state_q == ST_HALT);
  assign op_cycles = cyc_q;
  assign op_done = done_q;
  assign ea_out = ea_q;
  assign ea_valid = eav_q;
  assign xfer_cycles = xfer_q;

  sequence flag_op_taken;
    state_q == ST_OPCODE && byte_valid && byte_in == `EADF_OP_CARRY_SET;
  endsequence

  chk_carry_set_done: assert property (@(posedge clock) disable iff (sys_rst)
    flag_op_taken |=> flags_q.carry ##0 (!op_done)[*2] ##1 op_done)
    else $error("carry set did not finish in two cycles");
  chk_carry_invert: assert property (@(posedge clock) disable iff (sys_rst)
    (state_q == ST_OPCODE && byte_valid && byte_in == `EADF_OP_CARRY_INVERT)
    |=> flags_q.carry != $past(flags_q.carry))
    else $error("carry not inverted");
  chk_dir_flag: assert property (@(posedge clock) disable iff (sys_rst)
    (state_q == ST_OPCODE && byte_valid && byte_in == `EADF_OP_DIR_SET) |=> flags_q.direction)
    else $error("direction flag not set");
  chk_irq_flag: assert property (@(posedge clock) disable iff (sys_rst)
    (state_q == ST_OPCODE && byte_valid && byte_in == `EADF_OP_IRQ_CLEAR)
    |=> !flags_q.irq_enable)
    else $error("interrupt enable not cleared");
  chk_ea_cycles: assert property (@(posedge clock) disable iff (sys_rst)
    ea_valid && !ea_out.is_reg |-> op_cycles == `EADF_EA_CYCLES)
    else $error("address calculation cost not four cycles");
  chk_string_seg: assert property (@(posedge clock) disable iff (sys_rst)
    $rose(ea_valid) && $past(string_dest) |-> ea_out.seg == eadf_pkg::EADF_SEG_EXTRA)
    else $error("string destination not in extra segment");
  chk_halt_hold: assert property (@(posedge clock) disable iff (sys_rst)
    halted && !irq_seen_q |=> halted)
    else $error("halt left without interrupt");
  chk_word_xfer: assert property (@(posedge clock) disable iff (sys_rst)
    ea_valid |-> xfer_cycles == ($past(word_op) ? 6'($past(mem_xfers) * 4) : 6'h00))
    else $error("word transfer cost wrong");
endmodule // eadf_decode
`default_nettype wire

// ### test_eadf_decode.sv
// self-checking testbench for the effective address and flag control decoder
`timescale 1ns/1ps
`default_nettype none
`include "eadf_params.svh"

module test_eadf_decode;
  logic clock;
  logic sys_rst;
  logic byte_valid;
  logic [7:0] byte_in;
  eadf_pkg::eadf_regs_t regs;
  logic string_dest;
  logic word_op;
  logic [1:0] mem_xfers;
  logic test_n;
  logic irq_req;
  logic byte_ready;
  eadf_pkg::eadf_flags_t flags;
  logic lock_active;
  logic halted;
  logic [3:0] op_cycles;
  logic op_done;
  eadf_pkg::eadf_ea_t ea_out;
  logic ea_valid;
  logic [5:0] xfer_cycles;
  int fail_count;
  int comparisons;
  eadf_pkg::eadf_flags_t exp_flags;

  eadf_decode eadf_decode_i (
    .clock(clock), .sys_rst(sys_rst), .byte_valid(byte_valid), .byte_in(byte_in),
    .regs(regs), .string_dest(string_dest), .word_op(word_op), .mem_xfers(mem_xfers),
    .test_n(test_n), .irq_req(irq_req), .byte_ready(byte_ready), .flags(flags),
    .lock_active(lock_active), .halted(halted), .op_cycles(op_cycles), .op_done(op_done),
    .ea_out(ea_out), .ea_valid(ea_valid), .xfer_cycles(xfer_cycles)
  );

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  task automatic summarize();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD at %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic step();
    @(posedge clock);
    #1;
  endtask

  // a hung handshake ends the run at once rather than masking later results
  task automatic timed_out();
    fail_count++;
    summarize();
  endtask

  // byte_valid stays up between bytes so back-to-back bytes never toggle it
  task automatic send_byte(input logic [7:0] b);
    int n;
    byte_in = b;
    byte_valid = 1'b1;
    n = 0;
    while (byte_ready !== 1'b1 && n < 50) begin
      step();
      n++;
    end
    if (n == 50) timed_out();
    step();
  endtask

  task automatic idle();
    byte_valid = 1'b0;
    byte_in = 8'h00;
  endtask

  task automatic flag_op(input logic [7:0] b);
    int n;
    send_byte(b);
    idle();
    check(flags, exp_flags);
    n = 0;
    while (op_done !== 1'b1 && n < 20) begin
      step();
      n++;
    end
    if (n == 20) timed_out();
    check(n, 2);
    check(op_cycles, `EADF_FLAG_CYCLES);
  endtask

  task automatic flag_ops();
    exp_flags.carry = 1'b1;
    flag_op(`EADF_OP_CARRY_SET);
    exp_flags.carry = 1'b0;
    flag_op(`EADF_OP_CARRY_INVERT);
    exp_flags.carry = 1'b1;
    flag_op(`EADF_OP_CARRY_INVERT);
    exp_flags.carry = 1'b0;
    flag_op(`EADF_OP_CARRY_CLEAR);
    exp_flags.direction = 1'b1;
    flag_op(`EADF_OP_DIR_SET);
    exp_flags.direction = 1'b0;
    flag_op(`EADF_OP_DIR_CLEAR);
    exp_flags.irq_enable = 1'b1;
    flag_op(`EADF_OP_IRQ_SET);
    exp_flags.irq_enable = 1'b0;
    flag_op(`EADF_OP_IRQ_CLEAR);
  endtask

  function automatic logic [15:0] base_of(input logic [2:0] rm);
    case (rm)
      3'h0: return regs.bx + regs.si;
      3'h1: return regs.bx + regs.di;
      3'h2: return regs.bp + regs.si;
      3'h3: return regs.bp + regs.di;
      3'h4: return regs.si;
      3'h5: return regs.di;
      3'h6: return regs.bp;
      default: return regs.bx;
    endcase
  endfunction

  // prefix byte 8'h00 means no prefix is sent
  task automatic ea_op(input logic [7:0] pfx, input logic [7:0] modrm, input int ndisp,
                       input logic [15:0] disp, input logic [15:0] exp_addr,
                       input eadf_pkg::eadf_seg_t exp_seg);
    int n;
    if (pfx != 8'h00) send_byte(pfx);
    send_byte(8'h8B);
    send_byte(modrm);
    if (ndisp > 0) send_byte(disp[7:0]);
    if (ndisp > 1) send_byte(disp[15:8]);
    idle();
    n = 0;
    while (ea_valid !== 1'b1 && n < 10) begin
      step();
      n++;
    end
    if (n == 10) timed_out();
    check(ea_out.effective_address, exp_addr);
    check(ea_out.seg, exp_seg);
    check(ea_out.is_reg, (modrm[7:6] == `EADF_MOD_REG));
    if (modrm[7:6] != `EADF_MOD_REG) check(ea_out.cycles, `EADF_EA_CYCLES);
  endtask

  task automatic mem_forms();
    eadf_pkg::eadf_seg_t s;
    for (int k = 0; k < 8; k++) begin
      s = (k == 2 || k == 3 || k == 6) ? eadf_pkg::EADF_SEG_STACK : eadf_pkg::EADF_SEG_DATA;
      ea_op(8'h00, {2'h2, 3'h0, 3'(k)}, 2, 16'h1234, base_of(3'(k)) + 16'h1234, s);
    end
    ea_op(8'h00, 8'h04, 0, 16'h0000, regs.si, eadf_pkg::EADF_SEG_DATA);
    ea_op(8'h00, 8'h44, 1, 16'h0080, regs.si - 16'h0080, eadf_pkg::EADF_SEG_DATA);
    ea_op(8'h00, 8'h47, 1, 16'h007F, regs.bx + 16'h007F, eadf_pkg::EADF_SEG_DATA);
    ea_op(8'h00, 8'h06, 2, 16'hBEEF, 16'hBEEF, eadf_pkg::EADF_SEG_DATA);
  endtask

  task automatic overrides();
    for (int k = 0; k < 4; k++) begin
      ea_op(8'h26 | 8'(k << 3), 8'h80, 2, 16'h0010, base_of(3'h0) + 16'h0010,
            eadf_pkg::eadf_seg_t'(k));
    end
    // string destinations ignore the override entirely
    string_dest = 1'b1;
    ea_op(8'h2E, 8'h85, 2, 16'h0002, regs.di + 16'h0002, eadf_pkg::EADF_SEG_EXTRA);
    string_dest = 1'b0;
  endtask

  task automatic reg_forms();
    logic [15:0] r;
    for (int k = 0; k < 8; k++) begin
      r = (k % 4 == 0) ? regs.ax : (k % 4 == 1) ? regs.cx : (k % 4 == 2) ? regs.dx : regs.bx;
      ea_op(8'h00, {2'h3, 3'(k), 3'(k)}, 0, 16'h0000, 16'h0000,
            eadf_pkg::EADF_SEG_DATA);
      check(ea_out.reg_num, k);
      check(ea_out.byte_reg_val, (k < 4) ? r[7:0] : r[15:8]);
    end
  endtask

  task automatic lock_prefix();
    send_byte(`EADF_OP_LOCK);
    send_byte(8'h8B);
    check(lock_active, 1'b1);
    send_byte(8'h07);
    idle();
    repeat (4) step();
  endtask

  task automatic word_costs();
    word_op = 1'b1;
    mem_xfers = 2'h3;
    ea_op(8'h00, 8'h07, 0, 16'h0000, regs.bx, eadf_pkg::EADF_SEG_DATA);
    check(xfer_cycles, 6'h0C);
    word_op = 1'b0;
    ea_op(8'h00, 8'h07, 0, 16'h0000, regs.bx, eadf_pkg::EADF_SEG_DATA);
    check(xfer_cycles, 6'h00);
  endtask

  // wait must hold while test is high, then release; nop runs its three cycles
  task automatic wait_nop();
    int n;
    test_n = 1'b1;
    send_byte(`EADF_OP_WAIT);
    idle();
    repeat (12) step();
    check(op_done, 1'b0);
    check(byte_ready, 1'b0);
    test_n = 1'b0;
    n = 0;
    while (op_done !== 1'b1 && n < 20) begin
      step();
      n++;
    end
    if (n == 20) timed_out();
    check(op_cycles, `EADF_WAIT_CYCLES);
    send_byte(`EADF_OP_NOP);
    idle();
    n = 0;
    while (op_done !== 1'b1 && n < 20) begin
      step();
      n++;
    end
    if (n == 20) timed_out();
    check(n, 3);
    check(op_cycles, `EADF_NOP_CYCLES);
  endtask

  task automatic halt_release();
    int n;
    send_byte(`EADF_OP_HALT);
    idle();
    repeat (3) step();
    check(halted, 1'b1);
    repeat (8) step();
    check(halted, 1'b1);
    irq_req = 1'b1;
    n = 0;
    while (halted !== 1'b0 && n < 10) begin
      step();
      n++;
    end
    if (n == 10) timed_out();
    irq_req = 1'b0;
    check(halted, 1'b0);
    repeat (4) step();
  endtask

  initial begin
    fail_count = 0;
    comparisons = 0;
    sys_rst = 1'b1;
    byte_valid = 1'b0;
    byte_in = 8'h00;
    regs = '{ax: 16'h1A2B, cx: 16'h3C4D, dx: 16'h5E6F, bx: 16'h0100,
              bp: 16'h0200, si: 16'h0030, di: 16'h0004};
    string_dest = 1'b0;
    word_op = 1'b0;
    mem_xfers = 2'h0;
    test_n = 1'b0;
    irq_req = 1'b0;
    exp_flags = '0;
    repeat (2) step();
    sys_rst = 1'b0;
    check(flags, 3'h0);
    check(byte_ready, 1'b1);
    flag_ops();
    mem_forms();
    overrides();
    reg_forms();
    lock_prefix();
    word_costs();
    wait_nop();
    halt_release();
    summarize();
  end
endmodule // test_eadf_decode
`default_nettype wire
